// ### design/txwb_top.sv
// Purpose: transmit descriptor status collection and write-back
// Assumes: transmit engine reports line events as single-cycle pulses
// Notes:   word 0 written once per frame with ownership cleared
`timescale 1ns/10ps
// Notes on behaviour
// - deferral sets bit 11, not full-duplex
// - collision with standard backoff sets deferred
// - exactly one collision then sent: bit 10
// - two or more collisions then sent: bit 9
// - retry limit exhausted aborts, sets bit 8
// - collision after 512 bit times: bit 7
// - carrier low during frame sets bit 6
// - no heartbeat at end sets bit 5
// - fifo empty mid-frame: bit 4, suspend
// - host-owned next descriptor: bit 2, suspend
// - stopped transmit process sets bit 1
// - good frame sets bit 0 despite minor flags
// - good clear on severe errors
// - buffer 1 address from bits 63:32
// - buffer 2 address from bits 31:0
// - clear bit 63 when frame closes
// - deferral beyond limit aborts, sets bit 12
module txwb_top
    import txwb_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        desc_load_in,
    input  wire logic [63:0] desc_word1_in,
    input  wire logic        frame_start_in,
    input  wire logic        frame_end_in,
    input  wire logic        defer_in,
    input  wire logic        collision_in,
    input  wire logic        crs_in,
    input  wire logic        collision_input,
    input  wire logic        fifo_empty_in,
    input  wire logic        next_host_owned_in,
    input  wire logic        stop_in,
    output logic [31:0]      buf1_addr_out,
    output logic [31:0]      buf2_addr_out,
    output logic             abort_out,
    output logic             suspended_out,
    output logic             wb_valid_out,
    output logic [31:0]      wb_word0_out,
    output logic             irq_out
);
    typedef enum {IDLE, SEND, CLOSE, SUSP} tx_state_e;
    tx_state_e state_r;

    logic [31:0]        ctrl_r;
    logic [31:0]        mask_r;
    logic [31:0]        last_r;
    logic [12:0]        flags_r;
    logic [RETRY_W-1:0] colls_r;
    logic [15:0]        bitcnt_r;
    logic [15:0]        defcnt_r;
    logic [15:0]        frames_r;
    logic [EV_W-1:0]    ev_set;
    logic [EV_W-1:0]    ev_flag;
    logic               apb_acc;
    logic               apb_wr;
    logic               rd_status;
    logic               fdx;
    logic               severe;
    logic               fatal_now;
    logic               sqe_seen_r;
    logic [31:0]        word0_nxt;

    assign apb_acc   = psel_in && penable_in;
    assign apb_wr    = apb_acc && pwrite_in;
    assign rd_status = apb_acc && !pwrite_in && paddr_in == A_STATUS;
    assign fdx       = ctrl_r[CTRL_FDX];

    // abort causes: retry exhausted, late collision, excess deferral, underflow
    assign fatal_now = (collision_in && colls_r == ctrl_r[CTRL_RETRY_L +: RETRY_W])
                     || (collision_in && bitcnt_r >= LATE_CYC)
                     || (defer_in && defcnt_r >= ctrl_r[CTRL_DEFER_L +: DEFER_W])
                     || fifo_empty_in;

    // control registers
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ctrl_r <= {DEFER_RST, 4'h0, RETRY_RST, 8'h00};
            mask_r <= STATUS_RST;
        end else begin
            if (apb_wr && paddr_in == A_CTRL) begin
                ctrl_r <= pwdata_in;
            end else begin
                ctrl_r[CTRL_POLL] <= 1'b0;
            end
            if (apb_wr && paddr_in == A_MASK) begin
                mask_r <= pwdata_in;
            end
        end
    end

    // buffer addresses, low bits forced aligned
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            buf1_addr_out <= STATUS_RST;
            buf2_addr_out <= STATUS_RST;
        end else if (desc_load_in) begin
            buf1_addr_out <= {desc_word1_in[BUF1_HI:BUF1_LO+ALIGN_BITS],
                              3'h0};
            buf2_addr_out <= {desc_word1_in[BUF2_HI:BUF2_LO+ALIGN_BITS],
                              3'h0};
        end
    end

    // frame state; resume only via host poll, never on its own
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= IDLE;
        end else begin
            case (state_r)
                IDLE: begin
                    if (next_host_owned_in) begin
                        state_r <= SUSP;
                    end else if (frame_start_in) begin
                        state_r <= SEND;
                    end
                end
                SEND: begin
                    if (fatal_now || frame_end_in) begin
                        state_r <= CLOSE;
                    end
                end
                CLOSE: begin
                    if (flags_r[ST_UNDF] || next_host_owned_in) begin
                        state_r <= SUSP;
                    end else begin
                        state_r <= IDLE;
                    end
                end
                SUSP: begin
                    if (ctrl_r[CTRL_POLL]) begin
                        state_r <= IDLE;
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    // counters for collisions, bit time and deferral
    always_ff @(posedge clk_in) begin
        if (!resetn_in || frame_start_in) begin
            colls_r  <= '0;
            bitcnt_r <= '0;
            defcnt_r <= '0;
        end else if (state_r == SEND) begin
            if (collision_in) begin
                colls_r  <= colls_r + 1'b1;
                bitcnt_r <= '0;
            end else if (bitcnt_r != 16'hFFFF) begin
                bitcnt_r <= bitcnt_r + 1'b1;
            end
            if (defer_in && defcnt_r != 16'hFFFF) begin
                defcnt_r <= defcnt_r + 1'b1;
            end
        end
    end

    // per-frame status collection
    always_ff @(posedge clk_in) begin
        if (!resetn_in || frame_start_in) begin
            flags_r    <= '0;
            sqe_seen_r <= 1'b0;
        end else if (state_r == SEND) begin
            if (defer_in && !fdx) begin
                flags_r[ST_DEFER] <= 1'b1;
            end
            if (collision_in && ctrl_r[CTRL_STDBO] && !fdx) begin
                flags_r[ST_DEFER] <= 1'b1;
            end
            if (collision_in && colls_r == ctrl_r[CTRL_RETRY_L +: RETRY_W]) begin
                flags_r[ST_EXCOL] <= 1'b1;
            end
            if (collision_in && bitcnt_r >= LATE_CYC) begin
                flags_r[ST_LCOL] <= 1'b1;
            end
            if (!crs_in) begin
                flags_r[ST_LCAR] <= 1'b1;
            end
            if (fifo_empty_in) begin
                flags_r[ST_UNDF] <= 1'b1;
            end
            if (defer_in && defcnt_r >= ctrl_r[CTRL_DEFER_L +: DEFER_W]) begin
                flags_r[ST_EXDEFER] <= 1'b1;
            end
            if (frame_end_in && collision_input) begin
                sqe_seen_r <= 1'b1;
            end
        end
    end

    assign severe = flags_r[ST_LCOL] || flags_r[ST_EXDEFER]
                  || flags_r[ST_EXCOL] || flags_r[ST_UNDF];

    always_comb begin
        word0_nxt = '0;
        word0_nxt[ST_EXDEFER:ST_UNDF] = flags_r[ST_EXDEFER:ST_UNDF];
        word0_nxt[ST_SCOL] = !severe && colls_r == 4'h1;
        word0_nxt[ST_MCOL] = !severe && colls_r > 4'h1;
        word0_nxt[ST_SQE]  = !sqe_seen_r && !fdx;
        word0_nxt[ST_NOBUF] = next_host_owned_in;
        word0_nxt[ST_PSTOP] = stop_in;
        word0_nxt[ST_GOOD]  = !severe;
        word0_nxt[OWN_BIT-32] = 1'b0;
    end

    // one write carries status and releases ownership
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wb_valid_out <= 1'b0;
            wb_word0_out <= STATUS_RST;
            last_r       <= STATUS_RST;
            frames_r     <= '0;
        end else if (state_r == CLOSE) begin
            wb_valid_out <= 1'b1;
            wb_word0_out <= word0_nxt;
            last_r       <= word0_nxt;
            frames_r     <= frames_r + 1'b1;
        end else begin
            wb_valid_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            abort_out     <= 1'b0;
            suspended_out <= 1'b0;
        end else begin
            abort_out     <= state_r == SEND && fatal_now;
            suspended_out <= state_r == SUSP;
        end
    end

    assign ev_set[EV_DONE]  = state_r == CLOSE;
    assign ev_set[EV_SUSP]  = state_r != SUSP && (
                              (state_r == CLOSE && flags_r[ST_UNDF])
                              || next_host_owned_in);
    assign ev_set[EV_STOP]  = stop_in;
    assign ev_set[EV_ALIGN] = desc_load_in && desc_word1_in[2:0] != 3'h0;

    // clear only what the read returned, so an event landing at the
    // setup edge is not wiped by the access edge
    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++) begin : g_ev
            txwb_sticky u_flag (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .set_in    (ev_set[gi]),
                .clear_in  (rd_status && prdata_out[gi]),
                .flag_out  (ev_flag[gi])
            );
        end
    endgenerate

    // apb slave, zero wait states; unmapped reads zero with error
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            prdata_out  <= STATUS_RST;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out     <= 1'b0;
        end else begin
            irq_out    <= |(ev_flag & mask_r[EV_W-1:0]);
            pready_out <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            prdata_out <= STATUS_RST;
            if (psel_in && !penable_in) begin
                if (paddr_in == A_CTRL) begin
                    prdata_out <= ctrl_r;
                end else if (paddr_in == A_STATUS) begin
                    prdata_out <= {28'h0, ev_flag};
                end else if (paddr_in == A_MASK) begin
                    prdata_out <= mask_r;
                end else if (paddr_in == A_LAST) begin
                    prdata_out <= last_r;
                end else if (paddr_in == A_BUF1) begin
                    prdata_out <= buf1_addr_out;
                end else if (paddr_in == A_BUF2) begin
                    prdata_out <= buf2_addr_out;
                end else if (paddr_in == A_COUNT) begin
                    prdata_out <= {16'h0, frames_r};
                end else begin
                    pslverr_out <= 1'b1;
                end
            end
        end
    end

    a_good_severe: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wb_valid_out |-> !(wb_word0_out[ST_GOOD] && wb_word0_out[ST_UNDF]))
        else $error("good flag with underflow");
    a_own_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_r == CLOSE |=> wb_valid_out && !wb_word0_out[OWN_BIT-32])
        else $error("ownership not released");
    a_undf_susp: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_r == CLOSE && flags_r[ST_UNDF] |=> ##1 suspended_out)
        else $error("underflow did not suspend");
    a_nobuf_susp: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_r == IDLE && next_host_owned_in |=> ##1 suspended_out)
        else $error("host descriptor did not suspend");
    a_susp_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_r == SUSP && !ctrl_r[CTRL_POLL] |=> state_r == SUSP)
        else $error("resumed without poll");
    a_fdx_defer: assert property (@(posedge clk_in) disable iff (!resetn_in)
        fdx && $stable(fdx) && state_r == SEND && defer_in && !collision_in
        |=> $stable(flags_r[ST_DEFER]))
        else $error("deferral flagged in full duplex");
    a_lcar_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_r == SEND && !crs_in && !frame_start_in |=> flags_r[ST_LCAR])
        else $error("carrier loss missed");
    a_abort_cause: assert property (@(posedge clk_in) disable iff (!resetn_in)
        abort_out |-> $past(state_r) == SEND)
        else $error("abort outside frame");
    a_buf_align: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(desc_load_in) |-> buf1_addr_out[2:0] == 3'h0
            && buf2_addr_out[31:3] == $past(desc_word1_in[31:3]))
        else $error("buffer address wrong");
endmodule

// ### common/txwb_pkg.sv
// Purpose: constants for the transmit status write-back block
// Assumes: 40 MHz system clock, APB register access
// Notes:   descriptor word 0 status layout and local register map
package txwb_pkg;
    localparam int ST_EXDEFER = 12;
    localparam int ST_DEFER   = 11;
    localparam int ST_SCOL    = 10;
    localparam int ST_MCOL    = 9;
    localparam int ST_EXCOL   = 8;
    localparam int ST_LCOL    = 7;
    localparam int ST_LCAR    = 6;
    localparam int ST_SQE     = 5;
    localparam int ST_UNDF    = 4;
    localparam int ST_NOBUF   = 2;
    localparam int ST_PSTOP   = 1;
    localparam int ST_GOOD    = 0;
    localparam int OWN_BIT    = 63;
    localparam int BUF1_HI    = 63;
    localparam int BUF1_LO    = 32;
    localparam int BUF2_HI    = 31;
    localparam int BUF2_LO    = 0;
    localparam int ALIGN_BITS = 3;

    localparam logic [11:0] A_CTRL   = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_MASK   = 12'h008;
    localparam logic [11:0] A_LAST   = 12'h00C;
    localparam logic [11:0] A_BUF1   = 12'h010;
    localparam logic [11:0] A_BUF2   = 12'h014;
    localparam logic [11:0] A_COUNT  = 12'h018;

    localparam int CTRL_FDX     = 0;
    localparam int CTRL_STDBO   = 1;
    localparam int CTRL_POLL    = 2;
    localparam int CTRL_RETRY_L = 8;
    localparam int RETRY_W      = 4;
    localparam int DEFER_W      = 16;
    localparam int CTRL_DEFER_L = 16;

    localparam int EV_W     = 4;
    localparam int EV_DONE  = 0;
    localparam int EV_SUSP  = 1;
    localparam int EV_STOP  = 2;
    localparam int EV_ALIGN = 3;

    localparam int LATE_BITS    = 512;
    localparam int BIT_NS_X10   = 1;
    localparam int CLK_NS       = 25;
    localparam logic [15:0] LATE_CYC = 16'(LATE_BITS * 100 / 1000 / CLK_NS);
    localparam logic [3:0]  RETRY_RST = 4'hF;
    localparam logic [15:0] DEFER_RST = 16'h0FFF;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
endpackage

// ### design/txwb_sticky.sv
// Purpose: one sticky event bit, set wins over read clear
// Assumes: synchronous active-low reset
// Notes:   used for interrupt status bits
`timescale 1ns/10ps
module txwb_sticky (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      flag_out
);
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule

// ### bench/txwb_host_model.sv
// Purpose: host memory side holding one transmit descriptor
// Assumes: driver may post buffer addresses that are not 8-byte aligned
// Notes:   keeps the last status word closed by the device
`timescale 1ns/10ps
module txwb_host_model (
    input  wire logic        clk_in,
    input  wire logic        post_in,
    input  wire logic [63:0] word1_in,
    input  wire logic        keep_in,
    input  wire logic        wb_valid_in,
    input  wire logic [31:0] wb_word0_in,
    output logic             desc_load_out,
    output logic [63:0]      desc_word1_out,
    output logic             next_host_owned_out,
    output logic [31:0]      closed_out,
    output int               n_closed_out
);
    // word 1 lines change every cycle once released, so stale data shows
    always @(posedge clk_in) begin
        desc_load_out <= post_in;
        desc_word1_out <= post_in ? word1_in : ~desc_word1_out;
        next_host_owned_out <= keep_in;
        if (wb_valid_in === 1'b1) begin
            closed_out <= wb_word0_in;
            n_closed_out <= n_closed_out + 1;
        end
    end
endmodule

// ### bench/txwb_top_tb_top.sv
// Purpose: self-checking bench for the status write-back block
// Assumes: 40 MHz clock, APB answers in the access cycle
// Notes:   frame events are per-cycle masks over eight send cycles
`timescale 1ns/10ps
module txwb_top_tb_top
    import txwb_pkg::*;
;
    typedef struct packed {
        logic [31:0] ct;
        logic [7:0]  cv;
        logic [7:0]  dv;
        logic [7:0]  lv;
        logic [7:0]  ev;
        logic        h;
        logic [15:0] ex;
        logic [15:0] mk;
    } row_s;
    // last row suspends, so the refused-start check follows the loop
    row_s tbl [11] = '{
        '{32'h0FFF0F00,8'h01,8'h0,8'h0,8'h0,1'b1,16'h0401,16'h0E01},
        '{32'h0FFF0F00,8'h03,8'h0,8'h0,8'h0,1'b1,16'h0201,16'h0E01},
        '{32'h0FFF0F00,8'h0,8'h01,8'h0,8'h0,1'b1,16'h0801,16'h0801},
        '{32'h0FFF0F02,8'h01,8'h0,8'h0,8'h0,1'b1,16'h0C01,16'h0E01},
        '{32'h0FFF0F01,8'h0,8'h01,8'h0,8'h0,1'b0,16'h0001,16'h0821},
        '{32'h0FFF0F00,8'h0,8'h0,8'h10,8'h0,1'b1,16'h0041,16'h0041},
        '{32'h0FFF0F00,8'h0,8'h0,8'h0,8'h0,1'b0,16'h0021,16'h0021},
        '{32'h0FFF0F00,8'h40,8'h0,8'h0,8'h0,1'b1,16'h0080,16'h0081},
        '{32'h0FFF0100,8'h03,8'h0,8'h0,8'h0,1'b1,16'h0100,16'h0101},
        '{32'h00020F00,8'h0,8'h3F,8'h0,8'h0,1'b1,16'h1000,16'h1001},
        '{32'h0FFF0F00,8'h0,8'h0,8'h0,8'h08,1'b1,16'h0010,16'h0011}
    };
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dload;
    logic [63:0] dword1;
    logic        hown;
    logic        fstart = 1'b0;
    logic        fend = 1'b0;
    logic        defer = 1'b0;
    logic        coll = 1'b0;
    logic        crs = 1'b1;
    logic        hb = 1'b0;
    logic        empty = 1'b0;
    logic        stop = 1'b0;
    logic        post = 1'b0;
    logic [63:0] pword1 = 64'h0;
    logic        keep = 1'b0;
    logic [31:0] buf1;
    logic [31:0] buf2;
    logic        abort;
    logic        susp;
    logic        wbv;
    logic [31:0] wbw;
    logic        irq;
    logic [31:0] closed;
    int          ncl;
    int          n_fail = 0;
    int          n_compared = 0;
    logic [31:0] q;
    logic [31:0] w;
    logic        e;
    logic        ia;
    int          lat;
    int          c;

    always #12.5 clk = ~clk;

    txwb_top u_txwb_top (
        .clk_in(clk), .resetn_in(resetn), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .desc_load_in(dload),
        .desc_word1_in(dword1), .frame_start_in(fstart),
        .frame_end_in(fend), .defer_in(defer), .collision_in(coll),
        .crs_in(crs), .collision_input(hb), .fifo_empty_in(empty),
        .next_host_owned_in(hown), .stop_in(stop),
        .buf1_addr_out(buf1), .buf2_addr_out(buf2),
        .abort_out(abort), .suspended_out(susp), .wb_valid_out(wbv),
        .wb_word0_out(wbw), .irq_out(irq)
    );

    txwb_host_model u_txwb_host_model (
        .clk_in(clk), .post_in(post), .word1_in(pword1),
        .keep_in(keep), .wb_valid_in(wbv), .wb_word0_in(wbw),
        .desc_load_out(dload), .desc_word1_out(dword1),
        .next_host_owned_out(hown), .closed_out(closed),
        .n_closed_out(ncl)
    );

    task automatic chk(input logic [31:0] g, x, m);
        n_compared++;
        if ((g & m) !== x) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, g & m, x);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) pen <= 1'b1;
        do begin
            @(posedge clk) n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] x, m);
        apb(1'b0, a, 32'h0);
        chk(q, x, m);
    endtask

    task automatic post_desc(input logic [63:0] d);
        @(posedge clk) post <= 1'b1;
        pword1 <= d;
        @(posedge clk) post <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // waits on the strobe or the host's count, since aborts close early
    task automatic frame(input row_s t);
        int c0;
        c0 = ncl;
        @(posedge clk) fstart <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) fstart <= 1'b0;
            coll <= t.cv[i];
            defer <= t.dv[i];
            crs <= ~t.lv[i];
            empty <= t.ev[i];
        end
        @(posedge clk) coll <= 1'b0;
        defer <= 1'b0;
        crs <= 1'b1;
        empty <= 1'b0;
        fend <= 1'b1;
        hb <= t.h;
        @(posedge clk) fend <= 1'b0;
        hb <= 1'b0;
        lat = 1;
        while (wbv !== 1'b1 && ncl == c0 && lat < 20) begin
            @(posedge clk) lat++;
        end
        @(posedge clk) w = closed;
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rdc(A_CTRL, 32'h0FFF0F00, 32'hFFFFFFFF);
        rdc(A_STATUS, 32'h0, 32'hFFFFFFFF);
        rdc(A_MASK, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 12'h01C, 32'h0);
        chk({31'h0, e}, 32'h1, 32'h1);
        chk(q, 32'h0, 32'hFFFFFFFF);
        frame(tbl[6] | 97'h1_0000_0000);
        chk(w, 32'h1, 32'h80001FFF);
        chk(32'(lat), 32'h3, 32'hFFFFFFFF);
        repeat (2) @(posedge clk);
        ia = irq;
        rdc(A_STATUS, 32'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        apb(1'b1, A_MASK, 32'hF);
        frame(tbl[6] | 97'h1_0000_0000);
        repeat (2) @(posedge clk);
        chk({31'h0, irq === ia}, 32'h0, 32'h1);
        rdc(A_STATUS, 32'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        @(posedge clk) stop <= 1'b1;
        repeat (3) @(posedge clk);
        stop <= 1'b0;
        rdc(A_STATUS, 32'h4, 32'h4);
        post_desc(64'h0000100800002010);
        chk(buf1, 32'h00001008, 32'hFFFFFFFF);
        chk(buf2, 32'h00002010, 32'hFFFFFFFF);
        rdc(A_BUF2, 32'h00002010, 32'hFFFFFFFF);
        post_desc(64'h0000100F00002013);
        chk(buf1, 32'h00001008, 32'hFFFFFFFF);
        rdc(A_STATUS, 32'h8, 32'h8);
        foreach (tbl[i]) begin
            apb(1'b1, A_CTRL, tbl[i].ct | 32'h4);
            frame(tbl[i]);
            chk(w, {16'h0, tbl[i].ex}, {16'h8000, tbl[i].mk});
        end
        chk({31'h0, susp}, 32'h1, 32'h1);
        c = ncl;
        frame(tbl[6]);
        chk(32'(ncl - c), 32'h0, 32'hFFFFFFFF);
        apb(1'b1, A_CTRL, 32'h0FFF0F04);
        repeat (3) @(posedge clk);
        chk({31'h0, susp}, 32'h0, 32'h1);
        // host takes the next descriptor back while this frame is sent
        fork
            frame(tbl[6] | 97'h1_0000_0000);
            begin
                repeat (3) @(posedge clk);
                keep <= 1'b1;
            end
        join
        chk(w, 32'h4, 32'h80000004);
        chk({31'h0, susp}, 32'h1, 32'h1);
        @(posedge clk) keep <= 1'b0;
        apb(1'b1, A_CTRL, 32'h0FFF0F04);
        repeat (3) @(posedge clk);
        chk({31'h0, susp}, 32'h0, 32'h1);
        @(posedge clk) keep <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, susp}, 32'h1, 32'h1);
        keep <= 1'b0;
        apb(1'b1, A_CTRL, 32'h0FFF0F04);
        conclude();
    end
endmodule
